// ==== shared/sps_pkg.sv ====
// constants and types shared by the speed-position switching axis
package sps_pkg;
  localparam int POS_W = 32;
  localparam int SPD_W = 16;
  localparam logic [15:0] ERR_OVERRUN = 16'h00D1;
  localparam logic [15:0] ERR_STROKE = 16'h00D2;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [1:0] SRC_MODULE = 2'h0;
  localparam logic [1:0] SRC_AMP_DOG = 2'h1;
  localparam logic [1:0] SRC_BUILTIN_DI = 2'h2;
  localparam logic [1:0] SRC_BIT_DEV = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SPEED = 3'b001,
    ST_POS = 3'b010,
    ST_DECEL = 3'b011,
    ST_STOP_SPD = 3'b100,
    ST_STOP_POS = 3'b101
  } axis_state_t;
endpackage

// ==== shared/switch_if.sv ====
// qualified switch event carried from input conditioner to sequencer
`timescale 1ns/1ps
interface switch_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// ==== logic/switch_input_cond.sv ====
// selects, synchronises and polarises the position-switch input
`timescale 1ns/1ps
module switch_input_cond (
  input wire logic ref_clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic [3:0] src_pins, // module, amp dog, builtin di, bit device
  input wire logic [1:0] src_sel, // which source is used
  input wire logic nc_contact, // 1: normally closed contact
  switch_if.src sw // active level and its rising edge
);
  logic [3:0] s1_reg, s2_reg, s3_reg;
  logic act_reg;
  logic agree;
  logic sel_now;
  // only the selected line counts; chatter on the others must not hold it off
  assign agree = (s2_reg[src_sel] == s3_reg[src_sel]);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
    end else begin
      s1_reg <= src_pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // any of four sources
  assign sel_now = s3_reg[src_sel] ^ nc_contact;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_reg <= 1'b0;
    end else if (agree) begin
      act_reg <= sel_now;
    end
  end
  assign sw.level = act_reg;
  assign sw.rise = agree && sel_now && !act_reg;
endmodule // switch_input_cond

// ==== logic/speed_position_switch_axis.sv ====
// speed-to-position switching sequencer for one axis
// What this block does
// - switch event is the input's rise to its active level, per contact type.
// - switch input taken from any of four selectable sources.
// - update command off at a start from idle clears feed value, then tracks motion.
// - update command on at start keeps feed value, then tracks motion.
// - travel distance from two words, changeable during speed mode.
// - negative travel at switch gives deceleration stop in position mode.
// - travel-change data latched at the switch instant.
// - distance since position mode kept in a readable register pair.
// - switch needs start accepted, speed mode running, switch enabled.
// - enable arriving after input active does not switch.
// - enable and input on at a start from idle: position only, no speed flag.
// - travel below deceleration distance starts deceleration at once.
// - overrun raises error flag and, without overstroke, minor error 209.
// - overrun never asserts positioning done.
// - no stroke check in speed mode; overstroke gives error 210 and stop.
// - restart accepted only after a stop of this control.
// - restart after speed-mode stop resumes speed mode.
// - restart after position-mode stop moves the remaining travel.
// - restart uses speed captured at the original start.
// - forward start increases address, reverse decreases.
// - position mode moves exactly the travel from the switch point.
`timescale 1ns/1ps
module speed_position_switch_axis #(
  parameter int POS_W = sps_pkg::POS_W,
  parameter int SPD_W = sps_pkg::SPD_W
) (
  input wire logic ref_clk, // 125 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic forward_speed_pos_start, // start pulse, forward
  input wire logic reverse_speed_pos_start, // start pulse, reverse
  input wire logic speed_pos_restart, // restart pulse
  input wire logic stop_cmd, // stop pulse
  input wire logic [SPD_W-1:0] cmd_speed, // commanded speed, units per cycle
  input wire logic [POS_W-1:0] travel_indirect, // two-word travel, signed
  input wire logic travel_change_valid, // travel-change register in use
  input wire logic [POS_W-1:0] travel_change_data, // travel-change register
  input wire logic feed_value_update_cmd, // keep feed value at start
  input wire logic switch_enable_cmd, // switch enable
  input wire logic [3:0] switch_src_pins, // four switch sources
  input wire logic [1:0] switch_src_sel, // switch source select
  input wire logic switch_nc_contact, // normally closed contact
  input wire logic [POS_W-1:0] decel_dist, // deceleration distance estimate
  input wire logic [POS_W-1:0] stroke_lo, // stroke lower limit
  input wire logic [POS_W-1:0] stroke_hi, // stroke upper limit
  output logic start_accept_flag, // control running
  output logic speed_controlling_flag, // speed mode active
  output logic positioning_done_flag, // normal completion
  output logic error_detect_flag, // error detected
  output logic [15:0] error_code, // minor error code
  output logic [POS_W-1:0] feed_value, // feed current value
  output logic [POS_W/2-1:0] travel_after_switch_low, // distance since switch, low
  output logic [POS_W/2-1:0] travel_after_switch_high, // distance since switch, high
  output logic [SPD_W-1:0] motor_speed, // speed sent to amplifier
  output logic motor_dir_rev // 1: address decreasing
);
  ////////////////////////////////////////////////////////////////////////
  switch_if sw ();
  switch_input_cond u_cond (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .src_pins(switch_src_pins),
    .src_sel(switch_src_sel),
    .nc_contact(switch_nc_contact),
    .sw(sw)
  );

  ////////////////////////////////////////////////////////////////////////
  sps_pkg::axis_state_t state_reg, state_next;
  logic [SPD_W-1:0] start_speed_reg;
  logic dir_rev_reg;
  logic [POS_W-1:0] travel_reg;
  logic [POS_W-1:0] moved_reg;
  logic [POS_W-1:0] feed_reg;
  logic accept_reg, spd_flag_reg, done_reg, err_reg;
  logic [15:0] err_code_reg;
  logic [SPD_W-1:0] speed_reg;
  logic armed_reg;
  logic start_any;
  logic [POS_W-1:0] travel_src;
  logic [POS_W-1:0] remain;
  logic [POS_W-1:0] step;
  logic [POS_W-1:0] feed_step;
  logic [POS_W-1:0] target;
  logic travel_neg;
  logic overrun;
  logic overstroke;
  logic switch_evt;
  logic moving;
  logic finish;
  logic start_take;
  logic [SPD_W-1:0] run_speed;

  assign start_any = forward_speed_pos_start || reverse_speed_pos_start;
  assign start_take = start_any && (state_reg == sps_pkg::ST_IDLE ||
                      state_reg == sps_pkg::ST_STOP_SPD || state_reg == sps_pkg::ST_STOP_POS);
  // travel-change register wins when used, else indirect two-word value
  assign travel_src = travel_change_valid ? travel_change_data : travel_indirect;
  assign travel_neg = travel_src[POS_W-1];
  assign overrun = !travel_neg && (travel_src < decel_dist);
  assign target = dir_rev_reg ? feed_reg - travel_src : feed_reg + travel_src;
  // stroke range judged only when position mode is entered
  assign overstroke = !travel_neg && ($signed(target) < $signed(stroke_lo) ||
                      $signed(target) > $signed(stroke_hi));
  // armed only when enable was on before the input went active
  assign switch_evt = sw.rise && accept_reg && state_reg == sps_pkg::ST_SPEED &&
                      switch_enable_cmd && armed_reg;
  assign remain = travel_reg - moved_reg;
  assign step = {{(POS_W-SPD_W){1'b0}}, speed_reg};
  assign moving = state_reg == sps_pkg::ST_SPEED || state_reg == sps_pkg::ST_POS ||
                  state_reg == sps_pkg::ST_DECEL;
  assign finish = state_reg == sps_pkg::ST_POS && remain <= step;
  // last step in position mode is clipped to land exactly on the travel
  assign feed_step = finish ? remain : step;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sps_pkg::ST_IDLE: begin
        if (start_any && switch_enable_cmd && sw.level) begin
          state_next = (travel_neg || overrun || overstroke) ? sps_pkg::ST_DECEL
                       : sps_pkg::ST_POS;
        end else if (start_any) begin
          state_next = sps_pkg::ST_SPEED;
        end
      end
      sps_pkg::ST_SPEED: begin
        if (stop_cmd) begin
          state_next = sps_pkg::ST_STOP_SPD;
        end else if (switch_evt) begin
          state_next = (travel_neg || overrun || overstroke) ? sps_pkg::ST_DECEL
                       : sps_pkg::ST_POS;
        end
      end
      sps_pkg::ST_POS: begin
        if (finish) begin
          state_next = sps_pkg::ST_IDLE;
        end else if (stop_cmd) begin
          state_next = sps_pkg::ST_STOP_POS;
        end
      end
      sps_pkg::ST_DECEL: begin
        if (speed_reg == '0) begin
          state_next = sps_pkg::ST_IDLE;
        end
      end
      sps_pkg::ST_STOP_SPD: begin
        if (speed_pos_restart) begin
          state_next = sps_pkg::ST_SPEED;
        end else if (start_any) begin
          state_next = sps_pkg::ST_SPEED;
        end
      end
      sps_pkg::ST_STOP_POS: begin
        if (speed_pos_restart) begin
          state_next = sps_pkg::ST_POS;
        end else if (start_any) begin
          state_next = sps_pkg::ST_SPEED;
        end
      end
      default: state_next = sps_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= sps_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start parameters captured once; restart never re-reads cmd_speed
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_speed_reg <= '0;
      dir_rev_reg <= 1'b0;
    end else if (start_take) begin
      start_speed_reg <= cmd_speed;
      dir_rev_reg <= reverse_speed_pos_start && !forward_speed_pos_start;
    end
  end

  // input already active when enable rises: event must not count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_reg <= 1'b0;
    end else if (!switch_enable_cmd) begin
      armed_reg <= 1'b0;
    end else if (!sw.level) begin
      armed_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // a fresh start runs at once at the commanded speed; a resume uses the captured one
  always_comb begin
    run_speed = start_speed_reg;
    if (start_take) begin
      run_speed = cmd_speed;
    end
  end

  // speed profile: deceleration is a simple step-down by one unit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      speed_reg <= '0;
    end else begin
      case (state_next)
        sps_pkg::ST_SPEED, sps_pkg::ST_POS: begin
          speed_reg <= run_speed;
        end
        sps_pkg::ST_DECEL: begin
          if (speed_reg != '0) begin
            speed_reg <= speed_reg - {{(SPD_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          speed_reg <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // travel latched at the switch; moved distance restarts from zero there
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      travel_reg <= '0;
      moved_reg <= '0;
    end else if ((switch_evt || (state_reg == sps_pkg::ST_IDLE && start_any &&
                 switch_enable_cmd && sw.level)) && !stop_cmd) begin
      travel_reg <= travel_src;
      moved_reg <= '0;
    end else if (state_reg == sps_pkg::ST_POS || (state_reg == sps_pkg::ST_DECEL &&
                 travel_reg != '0)) begin
      moved_reg <= moved_reg + feed_step;
    end
  end

  // feed value: cleared at a start from idle unless update command holds it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      feed_reg <= '0;
    end else if (start_any && state_reg == sps_pkg::ST_IDLE && !feed_value_update_cmd) begin
      feed_reg <= '0;
    end else if (moving) begin
      feed_reg <= dir_rev_reg ? feed_reg - feed_step : feed_reg + feed_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      accept_reg <= 1'b0;
    end else begin
      accept_reg <= state_next != sps_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      spd_flag_reg <= 1'b0;
    end else begin
      spd_flag_reg <= state_next == sps_pkg::ST_SPEED;
    end
  end

  // completion wins over a clearing pulse in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (start_any || speed_pos_restart) begin
      done_reg <= 1'b0;
    end
  end

  // errors stick until the next start
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_reg <= 1'b0;
      err_code_reg <= sps_pkg::ERR_NONE;
    end else if (state_next == sps_pkg::ST_DECEL && state_reg != sps_pkg::ST_DECEL &&
                 (overstroke || overrun)) begin
      err_reg <= 1'b1;
      err_code_reg <= overstroke ? sps_pkg::ERR_STROKE : sps_pkg::ERR_OVERRUN;
    end else if (start_any && state_reg == sps_pkg::ST_IDLE) begin
      err_reg <= 1'b0;
      err_code_reg <= sps_pkg::ERR_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      travel_after_switch_low <= '0;
      travel_after_switch_high <= '0;
    end else begin
      travel_after_switch_low <= moved_reg[POS_W/2-1:0];
      travel_after_switch_high <= moved_reg[POS_W-1:POS_W/2];
    end
  end

  assign start_accept_flag = accept_reg;
  assign speed_controlling_flag = spd_flag_reg;
  assign positioning_done_flag = done_reg;
  assign error_detect_flag = err_reg;
  assign error_code = err_code_reg;
  assign feed_value = feed_reg;
  assign motor_speed = speed_reg;
  assign motor_dir_rev = dir_rev_reg;
endmodule // speed_position_switch_axis

// ==== tb/sps_axis_props.sv ====
// concurrent checks on the speed-position switching axis ports
`timescale 1ns/1ps
module sps_axis_props #(
  parameter int POS_W = 32,
  parameter int SPD_W = 16
) (
  input wire logic ref_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic forward_speed_pos_start, // fwd start
  input wire logic reverse_speed_pos_start, // rev start
  input wire logic speed_pos_restart, // restart
  input wire logic switch_enable_cmd, // switch enable
  input wire logic [SPD_W-1:0] cmd_speed, // commanded speed
  input wire logic start_accept_flag, // accept
  input wire logic speed_controlling_flag, // speed mode
  input wire logic positioning_done_flag, // done
  input wire logic error_detect_flag, // error
  input wire logic [15:0] error_code, // error code
  input wire logic [SPD_W-1:0] motor_speed, // speed out
  input wire logic motor_dir_rev // direction out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_fwd;
    forward_speed_pos_start && !reverse_speed_pos_start && !start_accept_flag;
  endsequence
  sequence s_rev;
    reverse_speed_pos_start && !forward_speed_pos_start && !start_accept_flag;
  endsequence
  a_fwd_dir: assert property (s_fwd |=> start_accept_flag && !motor_dir_rev)
    else $error("forward start gave wrong direction");
  a_rev_dir: assert property (s_rev |=> start_accept_flag && motor_dir_rev)
    else $error("reverse start gave wrong direction");
  a_start_speed: assert property ((s_fwd ##0 !switch_enable_cmd) |=>
    speed_controlling_flag && motor_speed == $past(cmd_speed))
    else $error("start speed not taken");
  a_done_accept: assert property ($rose(positioning_done_flag) |=> !start_accept_flag)
    else $error("accept still set after done");
  a_err_no_done: assert property (error_detect_flag |-> !positioning_done_flag)
    else $error("done set together with error");
  a_code_flag: assert property (error_code != sps_pkg::ERR_NONE |-> error_detect_flag)
    else $error("error code without error flag");
  a_speed_accept: assert property (speed_controlling_flag |->
    start_accept_flag && !positioning_done_flag)
    else $error("speed mode outside accepted control");
  a_restart_idle: assert property (speed_pos_restart && !start_accept_flag &&
    !forward_speed_pos_start && !reverse_speed_pos_start |=> !start_accept_flag)
    else $error("restart taken while idle");
  a_no_stroke_spd: assert property (speed_controlling_flag |->
    error_code != sps_pkg::ERR_STROKE)
    else $error("stroke error during speed mode");
endmodule // sps_axis_props

// ==== tb/switch_source_model.sv ====
// model of the external switching-input sources feeding the axis
`timescale 1ns/1ps
module switch_source_model (
  input wire logic ref_clk, // clock
  input wire logic active, // contact event wanted
  input wire logic [1:0] sel, // source in use
  input wire logic nc, // normally closed wiring
  output logic [3:0] pins // the four source lines
);
  logic noise_reg = 1'b0;
  // unused lines toggle so a wrong source select cannot pass by luck
  always_ff @(posedge ref_clk) noise_reg <= !noise_reg;
  always_comb begin
    pins = {4{noise_reg}};
    pins[sel] = active ^ nc;
  end
endmodule // switch_source_model

// ==== tb/tb_speed_position_switch_axis.sv ====
// self-checking bench for the speed-position switching axis
`timescale 1ns/1ps
module tb_speed_position_switch_axis;
  logic ref_clk = 1'b0, arst_n = 1'b0, stop_cmd = 1'b0, sw_active = 1'b0, fin_q, fin_q2;
  logic forward_speed_pos_start = 1'b0, reverse_speed_pos_start = 1'b0, speed_pos_restart = 1'b0;
  logic travel_change_valid = 1'b0, feed_value_update_cmd = 1'b0, switch_enable_cmd = 1'b0;
  logic switch_nc_contact = 1'b0, start_accept_flag, speed_controlling_flag, motor_dir_rev;
  logic positioning_done_flag, error_detect_flag;
  logic [15:0] cmd_speed = 16'h0004, error_code, motor_speed;
  logic [15:0] travel_after_switch_low, travel_after_switch_high;
  logic [1:0] switch_src_sel = 2'h0;
  logic [3:0] switch_src_pins;
  logic [31:0] travel_indirect = 32'h0, travel_change_data = 32'h0, decel_dist = 32'h0;
  logic [31:0] stroke_lo = 32'h8000_0000, stroke_hi = 32'h7FFF_FFFF, feed_value;
  logic [31:0] lfsr = 32'h2137;
  logic [32:0] exp_q[$];
  int n_mismatch = 0, total_checks = 0, hi_cnt = 0;
  speed_position_switch_axis i_dut (.*);
  switch_source_model i_src (.ref_clk, .active(sw_active), .sel(switch_src_sel),
    .nc(switch_nc_contact), .pins(switch_src_pins));
  initial forever #4 ref_clk = !ref_clk;
  //////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [32:0] exp, input logic [32:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cycle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cycle(1);
    s = 1'b0;
  endtask
  task automatic go(input logic rev, input logic [31:0] trav);
    travel_indirect = trav;
    if (rev) pulse(reverse_speed_pos_start);
    else pulse(forward_speed_pos_start);
  endtask
  task automatic wait_end();
    int k;
    for (k = 0; k < 3000 && positioning_done_flag !== 1'b1 && error_detect_flag !== 1'b1; k++)
      cycle(1);
    chk_bit("finished", 1'b1, k < 3000);
    cycle(3);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////
  // result seen two cycles after it rises, so the lagging distance pair has settled
  always @(posedge ref_clk) begin
    fin_q <= positioning_done_flag | error_detect_flag;
    fin_q2 <= fin_q;
    if (speed_controlling_flag === 1'b1) hi_cnt <= hi_cnt + 1;
    if (fin_q === 1'b1 && fin_q2 === 1'b0 && exp_q.size() > 0) begin
      if (positioning_done_flag === 1'b1)
        chk_word("distance", exp_q.pop_front(), {1'b0, travel_after_switch_high,
          travel_after_switch_low});
      else chk_word("error", exp_q.pop_front(), {17'h1_0000, error_code});
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    logic [31:0] trav, last_feed;
    int i;
    cycle(16);
    arst_n = 1'b1;
    switch_enable_cmd = 1'b1;
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      trav = {26'h0, lfsr[5:0]} + 32'h8;
      switch_src_sel = i[1:0];
      switch_nc_contact = i[0];
      feed_value_update_cmd = i[0];
      travel_change_valid = (i == 3);
      travel_change_data = 32'h1;
      exp_q.push_back({1'b0, trav});
      go(i[1], (i == 3) ? 32'h1 : trav);
      cycle(1);
      chk_bit("dir", i[1], motor_dir_rev);
      chk_bit("speed flag", 1'b1, speed_controlling_flag);
      if (i == 0) chk_bit("feed clear", 1'b1, feed_value < 32'h10);
      if (i == 1) chk_bit("feed kept", 1'b1, feed_value >= last_feed);
      travel_change_data = trav;
      cycle(3);
      sw_active = 1'b1;
      wait_end();
      chk_bit("accept", 1'b0, start_accept_flag);
      last_feed = feed_value;
      sw_active = 1'b0;
      cycle(4);
    end
    travel_change_valid = 1'b0;
    for (i = 0; i < 2; i++) begin
      decel_dist = (i == 0) ? 32'h0000_FFFF : 32'h0;
      stroke_hi = (i == 0) ? 32'h7FFF_FFFF : 32'h5;
      exp_q.push_back({17'h1_0000, (i == 0) ? sps_pkg::ERR_OVERRUN : sps_pkg::ERR_STROKE});
      go(1'b0, (i == 0) ? 32'h10 : 32'h1F4);
      cycle(6);
      chk_bit("no stroke check", 1'b0, error_detect_flag);
      sw_active = 1'b1;
      wait_end();
      chk_bit("done on error", 1'b0, positioning_done_flag);
      sw_active = 1'b0;
      cycle(4);
    end
    decel_dist = 32'h0;
    stroke_hi = 32'h7FFF_FFFF;
    switch_enable_cmd = 1'b0;
    go(1'b0, 32'h20);
    cycle(2);
    sw_active = 1'b1;
    cycle(6);
    switch_enable_cmd = 1'b1;
    cycle(8);
    chk_bit("late enable", 1'b1, speed_controlling_flag);
    cmd_speed = 16'h0009;
    pulse(stop_cmd);
    cycle(20);
    chk_word("stopped", 33'h0, {17'h0, motor_speed});
    pulse(speed_pos_restart);
    cycle(2);
    chk_bit("restart speed mode", 1'b1, speed_controlling_flag);
    chk_word("restart speed", 33'h4, {17'h0, motor_speed});
    sw_active = 1'b0;
    cycle(6);
    exp_q.push_back(33'h20);
    sw_active = 1'b1;
    cycle(7);
    pulse(stop_cmd);
    cycle(20);
    pulse(speed_pos_restart);
    wait_end();
    pulse(speed_pos_restart);
    cycle(3);
    chk_bit("restart refused", 1'b0, start_accept_flag);
    cmd_speed = 16'h0004;
    exp_q.push_back(33'h18);
    hi_cnt = 0;
    go(1'b0, 32'h18);
    wait_end();
    chk_bit("speed flag seen", 1'b0, hi_cnt != 0);
    // negative travel: switch is taken, then a stop with neither done nor error
    sw_active = 1'b0;
    cycle(6);
    go(1'b0, 32'hFFFF_FFF0);
    cycle(4);
    sw_active = 1'b1;
    cycle(30);
    chk_bit("negative travel done", 1'b0, positioning_done_flag);
    chk_bit("negative travel error", 1'b0, error_detect_flag);
    chk_bit("negative travel stop", 1'b0, start_accept_flag);
    chk_word("negative travel speed", 33'h0, {17'h0, motor_speed});
    chk_bit("all results", 1'b1, exp_q.size() == 0);
    end_sim();
  end
endmodule // tb_speed_position_switch_axis
bind speed_position_switch_axis sps_axis_props #(.POS_W(POS_W), .SPD_W(SPD_W)) i_props (
  .ref_clk, .arst_n, .forward_speed_pos_start, .reverse_speed_pos_start, .speed_pos_restart,
  .switch_enable_cmd, .cmd_speed, .start_accept_flag, .speed_controlling_flag,
  .positioning_done_flag, .error_detect_flag, .error_code, .motor_speed, .motor_dir_rev);
